// File: rtl/jtdr_pkg.sv
// Constants, states and decode for the scan data chains.
// Assumes one system clock that oversamples the test clock.
package jtdr_pkg;

    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam int DBG_W = 35;
    localparam int SYNC_W = 2;

    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_INTEST = 4'h1;
    localparam logic [3:0] IR_SAMPLE = 4'h2;
    localparam logic [3:0] IR_ABORT = 4'h8;
    localparam logic [3:0] IR_DP_ACCESS = 4'ha;
    localparam logic [3:0] IR_AP_ACCESS = 4'hb;
    localparam logic [3:0] IR_IDCODE = 4'he;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    // Fixed pattern loaded by Capture-IR
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    localparam logic BYPASS_CAPTURE = 1'b0;
    localparam logic ID_LSB = 1'b1;

    // Cells of one pin: input, output, output enable
    localparam int CELLS_PER_PIN = 3;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } jtdr_tap_e;

    typedef enum logic [2:0] {
        SEL_BYPASS, SEL_IDCODE, SEL_BSCAN, SEL_AP_ACCESS, SEL_DP_ACCESS, SEL_ABORT
    } jtdr_sel_e;

    function automatic jtdr_tap_e jtdr_tap_next(input jtdr_tap_e s, input logic tms);
        jtdr_tap_e n;
        n = TAP_RESET;
        case (s)
            TAP_RESET: n = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: n = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: n = tms ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: n = tms ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: n = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: n = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: n = tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: n = tms ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: n = tms ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: n = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: n = tms ? TAP_SEL_DR : TAP_IDLE;
            default: n = TAP_RESET;
        endcase
        return n;
    endfunction : jtdr_tap_next

    // Unknown codes fall back to bypass so the path never opens
    function automatic jtdr_sel_e jtdr_decode(input logic [3:0] ir);
        jtdr_sel_e s;
        s = SEL_BYPASS;
        case (ir)
            IR_EXTEST, IR_INTEST, IR_SAMPLE: s = SEL_BSCAN;
            IR_ABORT: s = SEL_ABORT;
            IR_DP_ACCESS: s = SEL_DP_ACCESS;
            IR_AP_ACCESS: s = SEL_AP_ACCESS;
            IR_IDCODE: s = SEL_IDCODE;
            default: s = SEL_BYPASS;
        endcase
        return s;
    endfunction : jtdr_decode

endpackage : jtdr_pkg

// File: rtl/jtdr_chain_if.sv
// Capture, shift and update strobes shared by all long chains.
// Assumes strobes are one clk_sys cycle wide, one per rising test clock edge.
`timescale 1ns/1ns
interface jtdr_chain_if;
    logic capture;
    logic shift;
    logic update;
    logic tdi;

    modport ctrl (output capture, output shift, output update, output tdi);
    modport chain (input capture, input shift, input update, input tdi);
endinterface : jtdr_chain_if

// File: rtl/jtdr_chain.sv
// One capture/shift/update data chain with a parallel hold stage.
// Assumes strobes come from the data chain controller on clk_sys.
`timescale 1ns/1ns
module jtdr_chain #(
    parameter int W = 35
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Strobes
    jtdr_chain_if.chain ctl,
    input wire logic sel,
    // Parallel sides
    input wire logic [W-1:0] cap_data,
    output logic [W-1:0] upd_data,
    output logic upd_stb,
    output logic sh_lsb
);

    typedef struct packed {
        logic [W-1:0] sh;
        logic [W-1:0] upd;
        logic stb;
    } jtdr_chain_s;

    jtdr_chain_s q;
    jtdr_chain_s d;

    always_comb
    begin
        d = q;
        d.stb = 1'b0;
        if (sel && ctl.capture)
        begin
            d.sh = cap_data;
        end
        else if (sel && ctl.shift)
        begin
            d.sh = {ctl.tdi, q.sh[W-1:1]}; // R21
        end
        else if (sel && ctl.update)
        begin
            // Hold stage keeps shifted data for later use
            d.upd = q.sh; // R12
            d.stb = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign upd_data = q.upd;
    assign upd_stb = q.stb;
    assign sh_lsb = q.sh[0];

endmodule : jtdr_chain

// File: rtl/jtdr_top.sv
// Data chains behind the test access port, with its controller and
// instruction register, all oversampled on clk_sys.
// Assumes clk_sys runs at least eight times faster than tck.
//
// Contract
// R1: Bypass gives shortest path from tdi to tdo
// R2: Six selectable data chains are provided
// R3: Identification chain is 32 bits, standard layout
// R4: Identification chain lsb always reads one
// R5: Bypass is one stage capturing zero
// R6: Identification shifts one fixed 32-bit constant
// R7: Identification is the default instruction
// R8: Boundary cells ordered counter-clockwise from port
// R9: Each pin gives input, output, enable cells
// R10: Reset pin has one input cell only
// R11: Sample captures pad values in Capture-DR
// R12: Preload data shifted in is kept
// R13: External/internal test drive pads or core inputs
// R14: Access-port access chain is 35 bits
// R15: Debug-port access chain is 35 bits
// R16: Abort chain is 35 bits
// R17: Four-bit instruction; undefined codes act as bypass
// R18: Identification loaded on reset or Test-Logic-Reset
// R19: Codes 0000/0001/0010 select boundary chain
// R20: Codes 1000/1010/1011 select abort, debug, access
// R21: Shift one bit per tck, lsb first
`timescale 1ns/1ns
module jtdr_top #(
    parameter int N_PINS = 8,
    // Arbitrary neutral identification value
    parameter logic [31:0] ID_VALUE = 32'h0000_1001
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe,
    // Pad side
    input wire logic [N_PINS-1:0] pad_in,
    input wire logic rst_pin_n,
    output logic [N_PINS-1:0] pad_out,
    output logic [N_PINS-1:0] pad_oe,
    // Core side
    input wire logic [N_PINS-1:0] core_out,
    input wire logic [N_PINS-1:0] core_oe,
    output logic [N_PINS-1:0] core_in,
    // Access-port access chain
    input wire logic [jtdr_pkg::DBG_W-1:0] ap_access_cap,
    output logic [jtdr_pkg::DBG_W-1:0] access_port_access_chain,
    output logic ap_access_stb,
    // Debug-port access chain
    input wire logic [jtdr_pkg::DBG_W-1:0] dp_access_cap,
    output logic [jtdr_pkg::DBG_W-1:0] debug_port_access_chain,
    output logic dp_access_stb,
    // Abort chain
    input wire logic [jtdr_pkg::DBG_W-1:0] abort_cap,
    output logic [jtdr_pkg::DBG_W-1:0] abort_chain,
    output logic abort_stb
);

    localparam int BS_W = jtdr_pkg::CELLS_PER_PIN * N_PINS + 1;
    localparam int RST_CELL = jtdr_pkg::CELLS_PER_PIN * N_PINS;

    typedef struct packed {
        logic [2:0] tck_s;
        logic [jtdr_pkg::SYNC_W-1:0] tms_s;
        logic [jtdr_pkg::SYNC_W-1:0] tdi_s;
        logic [jtdr_pkg::SYNC_W-1:0] trst_s;
        logic [N_PINS-1:0] pin_s0;
        logic [N_PINS-1:0] pin_s1;
        logic [jtdr_pkg::SYNC_W-1:0] rst_s;
        jtdr_pkg::jtdr_tap_e state;
        logic [jtdr_pkg::IR_W-1:0] ir_sh;
        logic [jtdr_pkg::IR_W-1:0] ir;
        logic byp;
        logic [jtdr_pkg::ID_W-1:0] id_sh;
        logic tdo;
        logic tdo_oe;
        logic [N_PINS-1:0] pad_out;
        logic [N_PINS-1:0] pad_oe;
        logic [N_PINS-1:0] core_in;
    } jtdr_top_s;

    jtdr_top_s q;
    jtdr_top_s d;

    jtdr_chain_if ctl ();

    logic rise;
    logic fall;
    jtdr_pkg::jtdr_sel_e sel;
    logic [BS_W-1:0] bs_cap;
    logic [BS_W-1:0] bs_upd;
    logic bs_lsb;
    logic ap_lsb;
    logic dp_lsb;
    logic ab_lsb;
    logic dr_lsb;
    logic [jtdr_pkg::ID_W-1:0] id_word;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    logic sh_ir;
    logic extest_on;
    logic intest_on;

    // Edges found on the synchronised test clock
    assign rise = q.tck_s[1] & ~q.tck_s[2];
    assign fall = ~q.tck_s[1] & q.tck_s[2];
    assign sel = jtdr_pkg::jtdr_decode(q.ir); // R17 R19 R20
    assign id_word = {ID_VALUE[jtdr_pkg::ID_W-1:1], jtdr_pkg::ID_LSB}; // R3 R4 R6

    assign cap_dr = (q.state == jtdr_pkg::TAP_CAP_DR);
    assign sh_dr = (q.state == jtdr_pkg::TAP_SH_DR);
    assign upd_dr = (q.state == jtdr_pkg::TAP_UPD_DR);
    assign sh_ir = (q.state == jtdr_pkg::TAP_SH_IR);

    assign ctl.capture = rise && cap_dr;
    assign ctl.shift = rise && sh_dr;
    assign ctl.update = rise && upd_dr;
    assign ctl.tdi = q.tdi_s[1];

    // Pad muxes look at the current instruction only, never at the chain select
    assign extest_on = (q.ir == jtdr_pkg::IR_EXTEST); // R13
    assign intest_on = (q.ir == jtdr_pkg::IR_INTEST); // R13

    // Pin k owns cells 3k..3k+2; pin 0 sits next to the test port
    always_comb
    begin
        bs_cap = '0;
        for (int k = 0; k < N_PINS; k++)
        begin
            bs_cap[jtdr_pkg::CELLS_PER_PIN*k+jtdr_pkg::CELL_IN] = q.pin_s1[k]; // R8 R9 R11
            bs_cap[jtdr_pkg::CELLS_PER_PIN*k+jtdr_pkg::CELL_OUT] = core_out[k]; // R9 R11
            bs_cap[jtdr_pkg::CELLS_PER_PIN*k+jtdr_pkg::CELL_OE] = core_oe[k]; // R9 R11
        end
        // Reset pin is observe only
        bs_cap[RST_CELL] = q.rst_s[1]; // R10
    end

    // Long chains share one strobe set; each acts only while selected
    jtdr_chain #(
        .W(BS_W)
    ) u_bscan (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ctl(ctl),
        .sel(sel == jtdr_pkg::SEL_BSCAN),
        .cap_data(bs_cap),
        .upd_data(bs_upd),
        .upd_stb(),
        .sh_lsb(bs_lsb)
    );

    jtdr_chain #(
        .W(jtdr_pkg::DBG_W)
    ) u_ap_access (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ctl(ctl),
        .sel(sel == jtdr_pkg::SEL_AP_ACCESS), // R14
        .cap_data(ap_access_cap),
        .upd_data(access_port_access_chain),
        .upd_stb(ap_access_stb),
        .sh_lsb(ap_lsb)
    );

    jtdr_chain #(
        .W(jtdr_pkg::DBG_W)
    ) u_dp_access (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ctl(ctl),
        .sel(sel == jtdr_pkg::SEL_DP_ACCESS), // R15
        .cap_data(dp_access_cap),
        .upd_data(debug_port_access_chain),
        .upd_stb(dp_access_stb),
        .sh_lsb(dp_lsb)
    );

    jtdr_chain #(
        .W(jtdr_pkg::DBG_W)
    ) u_abort (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ctl(ctl),
        .sel(sel == jtdr_pkg::SEL_ABORT), // R16
        .cap_data(abort_cap),
        .upd_data(abort_chain),
        .upd_stb(abort_stb),
        .sh_lsb(ab_lsb)
    );

    // Unselected long chains keep their bits; bypass and identification stages capture and shift in every DR scan
    always_comb
    begin
        case (sel) // R2
            jtdr_pkg::SEL_IDCODE: dr_lsb = q.id_sh[0];
            jtdr_pkg::SEL_BSCAN: dr_lsb = bs_lsb;
            jtdr_pkg::SEL_AP_ACCESS: dr_lsb = ap_lsb;
            jtdr_pkg::SEL_DP_ACCESS: dr_lsb = dp_lsb;
            jtdr_pkg::SEL_ABORT: dr_lsb = ab_lsb;
            default: dr_lsb = q.byp; // R1
        endcase
    end

    always_comb
    begin
        d = q;
        // Two-stage synchronisers, three stages for tck; stage 0 feeds stage 1 only
        d.tck_s = {q.tck_s[1:0], tck};
        d.tms_s = {q.tms_s[0], tms};
        d.tdi_s = {q.tdi_s[0], tdi};
        d.trst_s = {q.trst_s[0], trst_n};
        d.pin_s0 = pad_in;
        d.pin_s1 = q.pin_s0;
        d.rst_s = {q.rst_s[0], rst_pin_n};

        // Test reset outranks a rising tck edge seen in the same cycle
        if (!q.trst_s[1])
        begin
            d.state = jtdr_pkg::TAP_RESET;
            d.ir = jtdr_pkg::IR_IDCODE; // R7 R18
        end
        else if (rise)
        begin
            case (q.state)
                jtdr_pkg::TAP_RESET: d.ir = jtdr_pkg::IR_IDCODE; // R7 R18
                jtdr_pkg::TAP_CAP_DR:
                begin
                    d.byp = jtdr_pkg::BYPASS_CAPTURE; // R5
                    d.id_sh = id_word; // R6
                end
                jtdr_pkg::TAP_SH_DR:
                begin
                    d.byp = q.tdi_s[1]; // R1 R5 R21
                    d.id_sh = {q.tdi_s[1], q.id_sh[jtdr_pkg::ID_W-1:1]}; // R21
                end
                jtdr_pkg::TAP_CAP_IR: d.ir_sh = jtdr_pkg::IR_CAPTURE;
                jtdr_pkg::TAP_SH_IR: d.ir_sh = {q.tdi_s[1], q.ir_sh[jtdr_pkg::IR_W-1:1]}; // R17
                jtdr_pkg::TAP_UPD_IR: d.ir = q.ir_sh; // R17
                default: d.ir = q.ir;
            endcase
            d.state = jtdr_pkg::jtdr_tap_next(q.state, q.tms_s[1]);
        end

        // Output changes on the falling test clock edge
        if (fall)
        begin
            d.tdo_oe = sh_dr || sh_ir;
            d.tdo = sh_ir ? q.ir_sh[0] : dr_lsb; // R21
        end

        // Registered muxes, so a test mode switch never glitches a pad
        for (int k = 0; k < N_PINS; k++)
        begin
            if (extest_on)
            begin
                d.pad_out[k] = bs_upd[jtdr_pkg::CELLS_PER_PIN*k+jtdr_pkg::CELL_OUT]; // R13
                d.pad_oe[k] = bs_upd[jtdr_pkg::CELLS_PER_PIN*k+jtdr_pkg::CELL_OE]; // R13
            end
            else
            begin
                d.pad_out[k] = core_out[k];
                d.pad_oe[k] = core_oe[k];
            end
            if (intest_on)
            begin
                d.core_in[k] = bs_upd[jtdr_pkg::CELLS_PER_PIN*k+jtdr_pkg::CELL_IN]; // R13
            end
            else
            begin
                d.core_in[k] = q.pin_s1[k];
            end
        end
    end

    // Power-on reset also resets the controller; instruction starts as identification
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.state <= jtdr_pkg::TAP_RESET;
            q.ir <= jtdr_pkg::IR_IDCODE; // R18
            // Active-low synchronisers start idle so no false test reset follows
            q.trst_s <= '1;
            q.rst_s <= '1;
        end
        else
        begin
            q <= d;
        end
    end

    assign tdo = q.tdo;
    assign tdo_oe = q.tdo_oe;
    assign pad_out = q.pad_out;
    assign pad_oe = q.pad_oe;
    assign core_in = q.core_in;

endmodule : jtdr_top

// File: dv/jtdr_chk.sv
// Port-level checker for the scan data chains.
// Assumes tck is a slow level input oversampled by clk_sys.
`timescale 1ns/1ns
module jtdr_chk #(
    parameter int N_PINS = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Test port
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe,
    // Debug chains
    input wire logic [jtdr_pkg::DBG_W-1:0] access_port_access_chain,
    input wire logic ap_access_stb,
    input wire logic [jtdr_pkg::DBG_W-1:0] debug_port_access_chain,
    input wire logic dp_access_stb,
    input wire logic [jtdr_pkg::DBG_W-1:0] abort_chain,
    input wire logic abort_stb
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic any_stb;
    assign any_stb = ap_access_stb | dp_access_stb | abort_stb;

    stb_onehot_a: assert property ($onehot0({ap_access_stb, dp_access_stb, abort_stb}))
        else $error("two chain strobes at once");
    stb_pulse_a: assert property (any_stb |=> !any_stb)
        else $error("chain strobe longer than one cycle");
    ap_hold_a: assert property ($changed(access_port_access_chain) |-> ap_access_stb)
        else $error("access chain hold changed without strobe");
    dp_hold_a: assert property ($changed(debug_port_access_chain) |-> dp_access_stb)
        else $error("debug chain hold changed without strobe");
    ab_hold_a: assert property ($changed(abort_chain) |-> abort_stb)
        else $error("abort hold changed without strobe");
    tdo_fall_a: assert property ($changed(tdo) |-> !tck && !$past(tck))
        else $error("tdo moved away from a falling tck");
    oe_fall_a: assert property ($changed(tdo_oe) |-> !tck && !$past(tck))
        else $error("tdo_oe moved away from a falling tck");
    oe_hold_a: assert property ($rose(tdo_oe) |=> tdo_oe [*6])
        else $error("shift window shorter than one tck");
    stb_noshift_a: assert property (any_stb |-> !tdo_oe && !$past(tdo_oe))
        else $error("strobe during shift");
    trst_idle_a: assert property (!trst_n [*6] |-> !tdo_oe)
        else $error("test reset did not stop shifting");

    cover property (ap_access_stb);
    cover property (dp_access_stb);
    cover property (abort_stb);
endmodule : jtdr_chk

bind jtdr_top jtdr_chk #(.N_PINS(N_PINS)) chk (.clk_sys(clk_sys), .reset_n(reset_n), .tck(tck),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .access_port_access_chain(access_port_access_chain),
    .ap_access_stb(ap_access_stb), .debug_port_access_chain(debug_port_access_chain),
    .dp_access_stb(dp_access_stb), .abort_chain(abort_chain), .abort_stb(abort_stb));

// File: dv/jtdr_host.sv
// Test host model driving the test port pins.
// Assumes clk_sys oversamples tck; tck idles low between scans.
`timescale 1ns/1ns
module jtdr_host (
    // Clock
    input wire logic clk_sys,
    // Test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One tck period of 800 ns, tdo taken just before the rise
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk_sys);
        q = tdo;
        tck = 1'b1;
        repeat (4) @(negedge clk_sys);
        tck = 1'b0;
    endtask : tick

    task automatic to_idle();
        logic q;
        repeat (5) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask : to_idle

    // From Idle through one scan, lsb first, back to Idle
    task automatic scan(input logic ir, input int n, input logic [34:0] din, output logic [34:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, 1'b0, q);
        if (ir)
            tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask : scan
endmodule : jtdr_host

// File: dv/tb_top.sv
// Self-checking bench for jtdr_top with the test host model.
// Assumes the host drives tck, tms and tdi; the rest is set here.
`timescale 1ns/1ns
module tb_top;
    localparam int NP = 8;
    localparam int BW = 3 * NP + 1;
    // Arbitrary identification value, bit 0 left clear on purpose
    localparam logic [31:0] ID_VAL = 32'h0000_1000;

    logic clk_sys, reset_n, trst_n, rst_pin_n, tck, tms, tdi, tdo, tdo_oe, q;
    logic [NP-1:0] pad_in, pad_out, pad_oe, core_out, core_oe, core_in;
    logic [34:0] ap_cap, dp_cap, ab_cap, ap_q, dp_q, ab_q, rd;
    logic ap_stb, dp_stb, ab_stb;
    int miscompares = 0;
    int n_compared = 0;

    jtdr_top #(.N_PINS(NP), .ID_VALUE(ID_VAL)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in),
        .rst_pin_n(rst_pin_n), .pad_out(pad_out), .pad_oe(pad_oe), .core_out(core_out),
        .core_oe(core_oe), .core_in(core_in), .ap_access_cap(ap_cap), .access_port_access_chain(ap_q),
        .ap_access_stb(ap_stb), .dp_access_cap(dp_cap), .debug_port_access_chain(dp_q), .dp_access_stb(dp_stb),
        .abort_cap(ab_cap), .abort_chain(ab_q), .abort_stb(ab_stb));
    jtdr_host host (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [34:0] got, input logic [34:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task automatic set_ir(input logic [3:0] code);
        host.scan(1'b1, 4, {31'h0, code}, rd);
    endtask : set_ir

    task automatic id_read();
        host.scan(1'b0, 32, 35'h0, rd);
        check(rd, {3'h0, ID_VAL | 32'h1});
    endtask : id_read

    task automatic t_bypass();
        logic [3:0] codes [9] = '{4'hf, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd};
        foreach (codes[i])
        begin
            set_ir(codes[i]);
            host.scan(1'b0, 8, 35'hb4, rd);
            check(rd, 35'h68);
        end
        host.to_idle();
        id_read();
    endtask : t_bypass

    task automatic t_debug();
        logic [34:0] cap [3];
        logic [34:0] hold [3];
        logic [34:0] din;
        cap = '{ab_cap, dp_cap, ap_cap};
        hold = '{35'h0, 35'h0, 35'h0};
        for (int j = 0; j < 3; j++)
        begin
            din = {3'(j + 5), 32'h5a3c_96e1};
            set_ir(j == 0 ? 4'h8 : j == 1 ? 4'ha : 4'hb);
            host.scan(1'b0, 35, din, rd);
            check(rd, cap[j]);
            hold[j] = din;
            repeat (2) @(negedge clk_sys);
            check(ab_q, hold[0]);
            check(dp_q, hold[1]);
            check(ap_q, hold[2]);
        end
    endtask : t_debug

    task automatic t_boundary();
        logic [34:0] e, pre, eo, eoe, ei;
        pre = 35'h0_00d3_c5a7;
        e = '0;
        eo = '0;
        eoe = '0;
        ei = '0;
        for (int k = 0; k < NP; k++)
        begin
            e[3 * k +: 3] = {core_oe[k], core_out[k], pad_in[k]};
            eo[k] = pre[3 * k + 1];
            eoe[k] = pre[3 * k + 2];
            ei[k] = pre[3 * k];
        end
        e[BW - 1] = rst_pin_n;
        check({27'h0, pad_out}, {27'h0, core_out});
        check({27'h0, core_in}, {27'h0, pad_in});
        set_ir(4'h2);
        host.scan(1'b0, BW, pre, rd);
        check(rd, e);
        set_ir(4'h0);
        core_out = 8'h00;
        repeat (3) @(negedge clk_sys);
        check({27'h0, pad_out}, eo);
        check({27'h0, pad_oe}, eoe);
        set_ir(4'h1);
        pad_in = 8'h00;
        repeat (4) @(negedge clk_sys);
        check({27'h0, core_in}, ei);
    endtask : t_boundary

    task automatic t_trst();
        trst_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        trst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check({27'h0, core_in}, {27'h0, pad_in});
        host.tick(1'b0, 1'b0, q);
        id_read();
    endtask : t_trst

    initial
    begin
        reset_n = 1'b0;
        trst_n = 1'b1;
        rst_pin_n = 1'b0;
        pad_in = 8'h96;
        core_out = 8'h3c;
        core_oe = 8'ha5;
        ap_cap = 35'h5_1234_5678;
        dp_cap = 35'h2_9abc_def0;
        ab_cap = 35'h7_0f0f_3c3c;
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        host.tick(1'b0, 1'b0, q);
        id_read();
        t_bypass();
        t_debug();
        t_boundary();
        t_trst();
        results();
    end

    // Whole run needs roughly 430 us
    initial
    begin
        #3_000_000;
        miscompares++;
        results();
    end
endmodule : tb_top
